// File: include/mas_pkg.sv
package mas_pkg;
  // operand and file geometry
  localparam int unsigned WORD_W     = 16;
  localparam int unsigned FILE_AW    = 8;
  localparam int unsigned FILE_DEPTH = 256;
  localparam int unsigned ROT_AMT    = 8;

  // s field values that switch the a field to the alternate set
  localparam logic [3:0] S_ALT_ONE = 4'h7;
  localparam logic [3:0] S_ALT_TWO = 4'ha;
  // s field value that selects the alternate b source set
  localparam logic [3:0] S_B_ALT   = 4'h8;

  // primary a codes
  localparam logic [2:0] A_FILE2   = 3'h0;
  localparam logic [2:0] A_PADDR   = 3'h1;
  localparam logic [2:0] A_INSTR   = 3'h2;
  localparam logic [2:0] A_INDEX   = 3'h3;
  localparam logic [2:0] A_ACCUM   = 3'h4;
  localparam logic [2:0] A_GENERAL = 3'h5;
  localparam logic [2:0] A_FILE1   = 3'h6;
  localparam logic [2:0] A_MEM     = 3'h7;

  // alternate a codes
  localparam logic [2:0] AA_SM_ONE = 3'h0;
  localparam logic [2:0] AA_MK_ONE = 3'h1;
  localparam logic [2:0] AA_SM_TWO = 3'h2;
  localparam logic [2:0] AA_MK_TWO = 3'h3;
  localparam logic [2:0] AA_DP_ROT = 3'h4;
  localparam logic [2:0] AA_DP_ACC = 3'h5;
  localparam logic [2:0] AA_DP_IDX = 3'h6;
  localparam logic [2:0] AA_DP_QUO = 3'h7;

  // reset and fill values
  localparam logic [WORD_W-1:0] OPERAND_RST = 16'h0000;
  localparam logic [WORD_W-1:0] ALL_ONES    = 16'hffff;
endpackage : mas_pkg

// File: rtl/mas_reg_file.sv
module mas_reg_file
  import mas_pkg::*;
(
  // clock and reset
  input  wire logic                         clock_i,
  input  wire logic                         rst_n_i,
  // write port
  input  wire logic                         wr_en_i,
  input  wire logic [mas_pkg::FILE_AW-1:0]  wr_addr_i,
  input  wire logic [mas_pkg::WORD_W-1:0]   wr_data_i,
  // read port, combinational
  input  wire logic [mas_pkg::FILE_AW-1:0]  rd_addr_i,
  output logic      [mas_pkg::WORD_W-1:0]   rd_data_o
);
  import mas_pkg::*;

  logic [WORD_W-1:0] mem_r   [FILE_DEPTH];
  logic [WORD_W-1:0] mem_nxt [FILE_DEPTH];

  always_comb begin
    mem_nxt = mem_r;
    if (wr_en_i) begin
      mem_nxt[wr_addr_i] = wr_data_i;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < FILE_DEPTH; i++) begin
        mem_r[i] <= OPERAND_RST;
      end
    end else begin
      mem_r <= mem_nxt;
    end
  end

  // read sees stored contents only, so a same-cycle write is not forwarded
  assign rd_data_o = mem_r[rd_addr_i];
endmodule : mas_reg_file

// File: rtl/mas_a_source.sv
module mas_a_source
  import mas_pkg::*;
(
  // clock and reset
  input  wire logic                         clock_i,
  input  wire logic                         rst_n_i,
  // microinstruction fields
  input  wire logic [3:0]                   s_field_i,
  input  wire logic [2:0]                   a_code_i,
  input  wire logic                         mem_read_cmd_i,
  // working and program registers
  input  wire logic [mas_pkg::WORD_W-1:0]   index_i,
  input  wire logic [mas_pkg::WORD_W-1:0]   accum_i,
  input  wire logic [mas_pkg::WORD_W-1:0]   general_i,
  input  wire logic [mas_pkg::WORD_W-1:0]   prog_addr_i,
  input  wire logic [mas_pkg::WORD_W-1:0]   instr_i,
  // status, mask and double precision registers
  input  wire logic [mas_pkg::WORD_W-1:0]   status_mode_one_i,
  input  wire logic [mas_pkg::WORD_W-1:0]   status_mode_two_i,
  input  wire logic [mas_pkg::WORD_W-1:0]   irq_mask_one_i,
  input  wire logic [mas_pkg::WORD_W-1:0]   irq_mask_two_i,
  input  wire logic [mas_pkg::WORD_W-1:0]   dp_accum_i,
  input  wire logic [mas_pkg::WORD_W-1:0]   dp_index_i,
  input  wire logic [mas_pkg::WORD_W-1:0]   dp_quot_i,
  // memory and external data
  input  wire logic [mas_pkg::WORD_W-1:0]   mem_rd_data_i,
  input  wire logic                         first_file_present_i,
  input  wire logic [mas_pkg::WORD_W-1:0]   ext_data_i,
  // file counters, current stored values
  input  wire logic [mas_pkg::FILE_AW-1:0]  upper_cnt_i,
  input  wire logic [mas_pkg::FILE_AW-1:0]  lower_cnt_i,
  // file write ports
  input  wire logic                         first_reg_file_we_i,
  input  wire logic                         second_reg_file_we_i,
  input  wire logic [mas_pkg::WORD_W-1:0]   file_wr_data_i,
  // selected operand
  output logic      [mas_pkg::WORD_W-1:0]   a_operand_o
);
  import mas_pkg::*;

  logic [WORD_W-1:0] first_rd;
  logic [WORD_W-1:0] second_rd;
  logic [WORD_W-1:0] dp_accum_rotated;
  logic              alt_set;
  logic              b_alt_set;
  logic [WORD_W-1:0] operand_r;
  logic [WORD_W-1:0] operand_nxt;
  logic              mem_read_prev_r;
  logic              mem_read_prev_nxt;

  // counters come in as stored values, so a step this cycle is not yet seen
  // lower counter addressing
  mas_reg_file u_first_reg_file (
    .clock_i   (clock_i),
    .rst_n_i   (rst_n_i),
    .wr_en_i   (first_reg_file_we_i),
    .wr_addr_i (lower_cnt_i),
    .wr_data_i (file_wr_data_i),
    .rd_addr_i (lower_cnt_i),
    .rd_data_o (first_rd)
  );

  mas_reg_file u_second_reg_file (
    .clock_i   (clock_i),
    .rst_n_i   (rst_n_i),
    .wr_en_i   (second_reg_file_we_i),
    .wr_addr_i (upper_cnt_i),
    .wr_data_i (file_wr_data_i),
    .rd_addr_i (upper_cnt_i),
    .rd_data_o (second_rd)
  );

  assign alt_set   = (s_field_i == S_ALT_ONE) || (s_field_i == S_ALT_TWO);
  assign b_alt_set = (s_field_i == S_B_ALT);
  assign dp_accum_rotated = {dp_accum_i[ROT_AMT-1:0], dp_accum_i[WORD_W-1:ROT_AMT]};

  always_comb begin
    mem_read_prev_nxt = mem_read_cmd_i;
    operand_nxt       = OPERAND_RST;
    if (alt_set) begin
      case (a_code_i)
        AA_SM_ONE: operand_nxt = status_mode_one_i;
        AA_SM_TWO: operand_nxt = status_mode_two_i;
        AA_MK_ONE: operand_nxt = irq_mask_one_i;
        AA_MK_TWO: operand_nxt = irq_mask_two_i;
        AA_DP_ROT: operand_nxt = dp_accum_rotated;
        AA_DP_ACC: operand_nxt = dp_accum_i;
        AA_DP_IDX: operand_nxt = dp_index_i;
        AA_DP_QUO: operand_nxt = dp_quot_i;
        default:   operand_nxt = OPERAND_RST;
      endcase
    end else begin
      case (a_code_i)
        A_FILE2:   operand_nxt = second_rd;
        A_PADDR:   operand_nxt = prog_addr_i;
        A_INSTR:   operand_nxt = instr_i;
        A_INDEX:   operand_nxt = index_i;
        A_ACCUM:   operand_nxt = accum_i;
        A_GENERAL: operand_nxt = general_i;
        A_FILE1:   operand_nxt = first_file_present_i ? first_rd : ext_data_i;
        A_MEM: begin
          operand_nxt = mem_rd_data_i;
          if (!mem_read_prev_r && !b_alt_set) begin
            operand_nxt = ALL_ONES;
          end
        end
        default:   operand_nxt = OPERAND_RST;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      operand_r       <= OPERAND_RST;
      mem_read_prev_r <= 1'b0;
    end else begin
      operand_r       <= operand_nxt;
      mem_read_prev_r <= mem_read_prev_nxt;
    end
  end

  assign a_operand_o = operand_r;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  function automatic logic is_alt(input logic [3:0] s);
    return (s == 4'h7) || (s == 4'ha);
  endfunction : is_alt

  sequence prim_code(logic [2:0] c);
    !is_alt(s_field_i) && a_code_i == c;
  endsequence

  sequence alt_code(logic [2:0] c);
    is_alt(s_field_i) && a_code_i == c;
  endsequence

  sequence read_then_mem;
    mem_read_cmd_i ##1 (prim_code(3'h7));
  endsequence

  sequence idle_then_mem;
    !mem_read_cmd_i ##1 (prim_code(3'h7) and s_field_i != 4'h8);
  endsequence

  // b-alternate keeps memory data even with no read issued
  sequence idle_then_balt;
    !mem_read_cmd_i ##1 (prim_code(3'h7) and s_field_i == 4'h8);
  endsequence

  index_route_a: assert property (prim_code(3'h3) |=> a_operand_o == $past(index_i))
    else $error("index register not routed");
  accum_route_a: assert property (prim_code(3'h4) |=> a_operand_o == $past(accum_i))
    else $error("accumulator not routed");
  general_route_a: assert property (prim_code(3'h5) |=> a_operand_o == $past(general_i))
    else $error("general register not routed");
  ext_route_a: assert property (
    prim_code(3'h6) and !first_file_present_i |=> a_operand_o == $past(ext_data_i))
    else $error("external source not routed");
  mem_read_a: assert property (
    read_then_mem |=> a_operand_o == $past(mem_rd_data_i))
    else $error("memory data not routed after read");
  mem_idle_a: assert property (idle_then_mem |=> a_operand_o == 16'hffff)
    else $error("idle memory did not give all ones");
  status_mode_a: assert property (
    alt_code(3'h2) |=> a_operand_o == $past(status_mode_two_i))
    else $error("status mode two not routed");
  mask_one_a: assert property (alt_code(3'h1) |=> a_operand_o == $past(irq_mask_one_i))
    else $error("mask one not routed");
  dp_rotate_a: assert property (
    alt_code(3'h4) |=> a_operand_o == {$past(dp_accum_i[7:0]), $past(dp_accum_i[15:8])})
    else $error("rotated double accumulator wrong");
  dp_quot_a: assert property (alt_code(3'h7) |=> a_operand_o == $past(dp_quot_i))
    else $error("double quotient not routed");
  alt_switch_a: assert property (
    s_field_i == 4'ha && a_code_i == 3'h0 |=> a_operand_o == $past(status_mode_one_i))
    else $error("alternate set not taken");
  paddr_route_a: assert property (prim_code(3'h1) |=> a_operand_o == $past(prog_addr_i))
    else $error("program address not routed");
  instr_route_a: assert property (prim_code(3'h2) |=> a_operand_o == $past(instr_i))
    else $error("instruction register not routed");
  file_one_a: assert property (
    prim_code(3'h6) and first_file_present_i |=> a_operand_o == $past(first_rd))
    else $error("first file entry not routed");
  file_two_a: assert property (
    prim_code(3'h0) |=> a_operand_o == $past(second_rd))
    else $error("second file entry not routed");
  mem_balt_a: assert property (
    idle_then_balt |=> a_operand_o == $past(mem_rd_data_i))
    else $error("memory data not routed under b-alternate");
  mask_two_a: assert property (alt_code(3'h3) |=> a_operand_o == $past(irq_mask_two_i))
    else $error("mask two not routed");
  dp_index_a: assert property (alt_code(3'h6) |=> a_operand_o == $past(dp_index_i))
    else $error("double index not routed");
endmodule : mas_a_source

// File: tb/mas_src_model.sv
// source registers as the sequencer side presents them, one distinct word each
module mas_src_model (
  // register words, fixed per index
  output logic [15:0] word_o [16]
);
  timeunit 1ns;
  timeprecision 1ps;
  // distinct nibbles so a swap or wrong rotate shows
  always_comb begin
    for (int k = 0; k < 16; k++) begin
      word_o[k] = {4'(k), 4'hc, 4'(15 - k), 4'h5};
    end
  end
endmodule : mas_src_model

// File: tb/mas_a_source_tb.sv
module mas_a_source_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mas_pkg::*;
  logic              clock_i, rst_n_i, rd_cmd, present, we_one, we_two;
  logic [3:0]        s_field;
  logic [2:0]        a_code;
  logic [7:0]        upper_cnt, lower_cnt;
  logic [WORD_W-1:0] wr_data, a_operand;
  logic [15:0]       word [16];
  int                n_mismatch, comparisons;

  mas_src_model model (.word_o(word));
  mas_a_source dut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .s_field_i(s_field), .a_code_i(a_code),
    .mem_read_cmd_i(rd_cmd), .index_i(word[0]), .accum_i(word[1]), .general_i(word[2]),
    .prog_addr_i(word[3]), .instr_i(word[4]), .status_mode_one_i(word[5]),
    .status_mode_two_i(word[6]), .irq_mask_one_i(word[7]), .irq_mask_two_i(word[8]),
    .dp_accum_i(word[9]), .dp_index_i(word[10]), .dp_quot_i(word[11]),
    .mem_rd_data_i(word[12]), .first_file_present_i(present), .ext_data_i(word[13]),
    .upper_cnt_i(upper_cnt), .lower_cnt_i(lower_cnt), .first_reg_file_we_i(we_one),
    .second_reg_file_we_i(we_two), .file_wr_data_i(wr_data), .a_operand_o(a_operand));

  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  // operand shows on the edge after the fields are driven, the same edge that samples them
  task automatic sel(input logic [3:0] s, input logic [2:0] a, input logic [15:0] exp);
    @(posedge clock_i);
    s_field <= s;
    a_code  <= a;
    @(posedge clock_i);
    #1;
    chk($sformatf("operand s=%h a=%0d", s, a), exp, a_operand);
  endtask : sel

  task automatic test_primary();
    int map [5] = '{3, 4, 0, 1, 2};
    for (int c = 1; c < 6; c++) begin
      sel(c[0] ? 4'h0 : 4'hb, 3'(c), word[map[c-1]]);
    end
    $display("test primary done");
  endtask : test_primary

  task automatic test_alternate();
    int map [8] = '{5, 7, 6, 8, 9, 9, 10, 11};
    for (int c = 0; c < 8; c++) begin
      sel(c[0] ? S_ALT_ONE : S_ALT_TWO, 3'(c), (c == 4) ? {word[9][7:0], word[9][15:8]}
          : word[map[c]]);
    end
    $display("test alternate done");
  endtask : test_alternate

  task automatic mem_case(input logic r, input logic [3:0] s, input logic [15:0] exp);
    @(posedge clock_i);
    rd_cmd  <= r;
    s_field <= 4'h0;
    a_code  <= A_ACCUM;
    @(posedge clock_i);
    rd_cmd  <= 1'b0;
    s_field <= s;
    a_code  <= A_MEM;
    @(posedge clock_i);
    #1;
    chk($sformatf("memory r=%0d s=%h", r, s), exp, a_operand);
  endtask : mem_case

  task automatic test_memory();
    mem_case(1'b1, 4'h0, word[12]);
    mem_case(1'b0, 4'h0, ALL_ONES);
    mem_case(1'b0, S_B_ALT, word[12]);
    mem_case(1'b1, S_B_ALT, word[12]);
    $display("test memory done");
  endtask : test_memory

  task automatic wr(input logic one, input logic [7:0] adr, input logic [15:0] d);
    @(posedge clock_i);
    we_one  <= one;
    we_two  <= !one;
    wr_data <= d;
    if (one) lower_cnt <= adr;
    else upper_cnt <= adr;
    @(posedge clock_i);
    we_one <= 1'b0;
    we_two <= 1'b0;
  endtask : wr

  task automatic test_files();
    wr(1'b0, 8'h05, 16'h5a3c);
    wr(1'b1, 8'h09, 16'hc3a5);
    sel(4'h0, A_FILE2, 16'h5a3c);
    sel(4'h0, A_FILE1, 16'hc3a5);
    @(posedge clock_i);
    upper_cnt <= 8'h06;
    sel(4'h0, A_FILE2, 16'h0000);
    @(posedge clock_i);
    present <= 1'b0;
    sel(4'h0, A_FILE1, word[13]);
    @(posedge clock_i);
    present <= 1'b1;
    $display("test files done");
  endtask : test_files

  initial begin
    {rst_n_i, rd_cmd, we_one, we_two} = 4'h0;
    present   = 1'b1;
    s_field   = 4'h0;
    a_code    = 3'h0;
    upper_cnt = 8'h00;
    lower_cnt = 8'h00;
    wr_data   = 16'h0000;
    repeat (5) @(posedge clock_i);
    chk("reset operand", OPERAND_RST, a_operand);
    rst_n_i <= 1'b1;
    test_primary();
    test_alternate();
    test_memory();
    test_files();
    give_verdict();
  end

  // whole run needs about 60 cycles
  initial begin
    repeat (1000) @(posedge clock_i);
    n_mismatch++;
    $display("unexpected watchdog: expected end, seen none");
    give_verdict();
  end
endmodule : mas_a_source_tb
